// file: src/isp_map.vh
/*
  Constants for the serial in-system programming host: instruction codes,
  field positions and timing counts. Assumes a 100 MHz system clock.
*/
`ifndef ISP_MAP_VH
`define ISP_MAP_VH

// System clock rate
`define ISP_CLK_HZ          100000000
// Serial clock half period in system cycles (500 ns half period)
`define ISP_SCK_HALF        8'd50
// Minimum serial clock low/high, in target CPU cycles
`define ISP_SCK_MIN_CPU     3
// Reset pulse high width in system cycles (two target cycles with margin)
`define ISP_RST_PULSE       32'd200
// Wait after entering reset, microseconds
`define ISP_ENTRY_WAIT_US   20000
`define ISP_ENTRY_WAIT      ((`ISP_ENTRY_WAIT_US * (`ISP_CLK_HZ / 1000000)))
// Wait delays, microseconds
`define ISP_FLASH_WAIT_US   4500
`define ISP_EEPROM_WAIT_US  9000
`define ISP_ERASE_WAIT_US   9000
`define ISP_FLASH_WAIT      ((`ISP_FLASH_WAIT_US * (`ISP_CLK_HZ / 1000000)))
`define ISP_EEPROM_WAIT     ((`ISP_EEPROM_WAIT_US * (`ISP_CLK_HZ / 1000000)))
`define ISP_ERASE_WAIT      ((`ISP_ERASE_WAIT_US * (`ISP_CLK_HZ / 1000000)))

// Instruction first/second bytes
`define ISP_PEN_B1          8'hac
`define ISP_PEN_B2          8'h53
`define ISP_ERASE_B2        8'h80
`define ISP_LOAD_B1         8'h40
`define ISP_LOAD_H_BIT      3
`define ISP_WPAGE_B1        8'h4c
`define ISP_RDPM_B1         8'h20
`define ISP_RDEE_B1         8'ha0
`define ISP_WREE_B1         8'hc0

// Command codes on the user port
`define ISP_CMD_ENABLE      3'h0
`define ISP_CMD_ERASE       3'h1
`define ISP_CMD_LOAD        3'h2
`define ISP_CMD_WPAGE       3'h3
`define ISP_CMD_RDPM        3'h4
`define ISP_CMD_RDEE        3'h5
`define ISP_CMD_WREE        3'h6
`define ISP_CMD_LEAVE       3'h7

`endif

// file: src/isp_fifo.v
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes a single clock; read data come from a register.
*/
`timescale 1ns/1ps
module isp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             nrst_i,
  // Write side
  input  wire [WIDTH-1:0] wr_data_i,
  input  wire             wr_valid_i,
  output wire             wr_ready_o,
  // Read side
  output reg  [WIDTH-1:0] rd_data_o,
  output reg              rd_valid_o,
  input  wire             rd_ready_i
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wp_reg;
  reg [AW-1:0]    rp_reg;
  reg [AW:0]      cnt_reg;
  wire            do_wr;
  wire            do_rd;

  assign wr_ready_o = (cnt_reg != DEPTH[AW:0]);
  assign do_wr      = wr_valid_i & wr_ready_o;
  // Refill the output register when empty or being taken
  assign do_rd      = (cnt_reg != {(AW+1){1'b0}}) & (~rd_valid_o | rd_ready_i);

  always @(posedge clk_i) begin
    if (do_wr) begin
      mem_reg[wp_reg] <= wr_data_i;
    end
  end

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp_reg     <= {AW{1'b0}};
      rp_reg     <= {AW{1'b0}};
      cnt_reg    <= {(AW+1){1'b0}};
      rd_data_o  <= {WIDTH{1'b0}};
      rd_valid_o <= 1'b0;
    end else begin
      if (do_wr) begin
        wp_reg <= (wp_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_reg + 1'b1;
      end
      if (do_rd) begin
        rd_data_o <= mem_reg[rp_reg];
        rp_reg    <= (rp_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_reg + 1'b1;
      end
      if (do_rd) begin
        rd_valid_o <= 1'b1;
      end else if (rd_ready_i) begin
        rd_valid_o <= 1'b0;
      end
      cnt_reg <= cnt_reg + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end
  end
endmodule // isp_fifo

// file: src/isp_host.v
/*
  Serial in-system programming host: drives reset, serial clock and data-in
  of the target, reads its data-out, and runs four-byte instructions.
  Assumes the target CPU clock is at least 8 MHz so a 500 ns half period
  keeps every serial clock phase above three target cycles.
*/
// Function
// - Hold target reset low for the whole programming session.
// - Send Programming Enable first; other commands except leave refused until enabled.
// - Serial clock low and high each last above three target cycles.
// - Present data-in before each rising serial clock edge.
// - Hold reset and clock low; pulse reset high to resynchronise.
// - Wait 20 ms after entering reset before Programming Enable.
// - Always shift four bytes; on bad echo pulse reset, wait, then idle for a new enable.
// - Load page buffer byte by byte with five word address bits.
// - Load low byte before high byte for each word address.
// - Commit page with write-page carrying the seven page bits.
// - Wait the Flash page delay after a page write.
// - Send nothing during a write wait.
// - EEPROM one byte per write, then wait the EEPROM delay.
// - Release reset high to end the session.
// - Full wait delays are always used, never polling.
// - Waits are 4.5 ms per page and 9.0 ms for EEPROM or erase.
// - Programming Enable bytes are 0xac then 0x53.
// - Load-page first byte 0100 H000, data in last byte.
// - Write-page first byte 0100 1100, address in bytes two and three.
`timescale 1ns/1ps
`include "isp_map.vh"
module isp_host #(
  parameter ENTRY_WAIT  = `ISP_ENTRY_WAIT,
  parameter FLASH_WAIT  = `ISP_FLASH_WAIT,
  parameter EEPROM_WAIT = `ISP_EEPROM_WAIT,
  parameter ERASE_WAIT  = `ISP_ERASE_WAIT,
  parameter FIFO_DEPTH  = 8
) (
  // Clock and reset
  input  wire        CLOCK_I,
  input  wire        NRST_I,
  // Command port
  input  wire        CMD_VALID_I,
  output wire        CMD_READY_O,
  input  wire [2:0]  CMD_OP_I,
  input  wire [11:0] CMD_ADDR_I,
  input  wire        CMD_HIGH_I,
  input  wire [7:0]  CMD_DATA_I,
  // Read data stream
  output wire [7:0]  RD_DATA_O,
  output wire        RD_VALID_O,
  input  wire        RD_READY_I,
  // Status
  output reg         ENABLED_O,
  output reg         SYNC_FAIL_O,
  output reg         REFUSED_O,
  // Target pins
  output reg         TGT_NRESET_O,
  output reg         TGT_SCK_O,
  output reg         TGT_MOSI_O,
  input  wire        TGT_MISO_I
);
  localparam ST_IDLE  = 3'd0;
  localparam ST_ENTRY = 3'd1;
  localparam ST_SHIFT = 3'd2;
  localparam ST_DONE  = 3'd3;
  localparam ST_WAIT  = 3'd4;
  localparam ST_PULSE = 3'd5;
  localparam ST_PUSH  = 3'd6;

  reg  [2:0]  state_reg;
  reg  [2:0]  op_reg;
  reg  [31:0] tx_reg;
  reg  [31:0] rx_reg;
  reg  [4:0]  bit_reg;
  reg  [7:0]  half_reg;
  reg  [31:0] wait_reg;
  reg         in_session_reg;
  reg         miso_s1_reg;
  reg         miso_s2_reg;
  reg         push_valid_reg;
  wire        fifo_ready;
  wire        take;
  wire        allowed;
  wire [31:0] frame;
  wire        half_tick;

  // FIFO pointer width follows its depth, so FIFO_DEPTH can change alone
  function integer isp_clog2;
    input integer value;
    integer v;
    begin
      v = value - 1;
      isp_clog2 = 0;
      while (v > 0) begin
        isp_clog2 = isp_clog2 + 1;
        v = v >> 1;
      end
    end
  endfunction

  localparam FIFO_AW = isp_clog2(FIFO_DEPTH);

  // Target data-out comes from another clock domain
  always @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      miso_s1_reg <= 1'b0;
      miso_s2_reg <= 1'b0;
    end else begin
      miso_s1_reg <= TGT_MISO_I;
      miso_s2_reg <= miso_s1_reg;
    end
  end

  // Half-period divider: one-cycle tick paces every serial clock phase
  always @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      half_reg <= 8'h00;
    end else if (state_reg != ST_SHIFT || half_tick) begin
      half_reg <= `ISP_SCK_HALF - 8'd1;
    end else begin
      half_reg <= half_reg - 8'd1;
    end
  end

  assign half_tick = (state_reg == ST_SHIFT) && (half_reg == 8'h00);

  // Build the four-byte frame for a command
  function [31:0] isp_frame;
    input [2:0]  op;
    input [11:0] addr;
    input        high;
    input [7:0]  data;
    begin
      case (op)
        `ISP_CMD_ENABLE: isp_frame = {`ISP_PEN_B1, `ISP_PEN_B2, 16'h0000};
        `ISP_CMD_ERASE:  isp_frame = {`ISP_PEN_B1, `ISP_ERASE_B2, 16'h0000};
        `ISP_CMD_LOAD:   isp_frame = {`ISP_LOAD_B1 | {4'h0, high, 3'h0}, 8'h00,
                                      3'b000, addr[4:0], data};
        `ISP_CMD_WPAGE:  isp_frame = {`ISP_WPAGE_B1, 4'h0, addr[11:8],
                                      addr[7:5], 5'h00, 8'h00};
        `ISP_CMD_RDPM:   isp_frame = {`ISP_RDPM_B1 | {4'h0, high, 3'h0}, 4'h0,
                                      addr[11:8], addr[7:0], 8'h00};
        `ISP_CMD_RDEE:   isp_frame = {`ISP_RDEE_B1, 7'h00, addr[8], addr[7:0], 8'h00};
        `ISP_CMD_WREE:   isp_frame = {`ISP_WREE_B1, 7'h00, addr[8], addr[7:0], data};
        default:         isp_frame = 32'h00000000;
      endcase
    end
  endfunction

  assign frame       = isp_frame(CMD_OP_I, CMD_ADDR_I, CMD_HIGH_I, CMD_DATA_I);
  // Nothing is accepted during a write wait or a shift
  assign CMD_READY_O = (state_reg == ST_IDLE);
  assign take        = CMD_VALID_I & CMD_READY_O;
  assign allowed     = (CMD_OP_I == `ISP_CMD_ENABLE) | (CMD_OP_I == `ISP_CMD_LEAVE) |
                       ENABLED_O;

  always @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_reg      <= ST_IDLE;
      op_reg         <= 3'h0;
      tx_reg         <= 32'h00000000;
      rx_reg         <= 32'h00000000;
      bit_reg        <= 5'h00;
      wait_reg       <= 32'h00000000;
      in_session_reg <= 1'b0;
      push_valid_reg <= 1'b0;
      ENABLED_O      <= 1'b0;
      SYNC_FAIL_O    <= 1'b0;
      REFUSED_O      <= 1'b0;
      TGT_NRESET_O   <= 1'b1;
      TGT_SCK_O      <= 1'b0;
      TGT_MOSI_O     <= 1'b0;
    end else begin
      REFUSED_O <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (take && !allowed) begin
            REFUSED_O <= 1'b1;
          end else if (take && CMD_OP_I == `ISP_CMD_LEAVE) begin
            TGT_NRESET_O   <= 1'b1;
            in_session_reg <= 1'b0;
            ENABLED_O      <= 1'b0;
          end else if (take) begin
            op_reg     <= CMD_OP_I;
            tx_reg     <= frame;
            bit_reg    <= 5'd31;
            TGT_SCK_O  <= 1'b0;
            TGT_MOSI_O <= frame[31];
            if (!in_session_reg) begin
              TGT_NRESET_O   <= 1'b0;
              in_session_reg <= 1'b1;
              wait_reg       <= ENTRY_WAIT;
              state_reg      <= ST_ENTRY;
            end else begin
              state_reg <= ST_SHIFT;
            end
          end
        end
        ST_ENTRY: begin
          if (wait_reg <= 32'd1) begin
            state_reg <= ST_SHIFT;
          end else begin
            wait_reg <= wait_reg - 32'd1;
          end
        end
        ST_SHIFT: begin
          if (half_tick) begin
            if (!TGT_SCK_O) begin
              // Rising edge: target samples data-in; data-out settled since fall
              TGT_SCK_O <= 1'b1;
              rx_reg    <= {rx_reg[30:0], miso_s2_reg};
            end else begin
              TGT_SCK_O <= 1'b0;
              if (bit_reg == 5'd0) begin
                state_reg <= ST_DONE;
              end else begin
                bit_reg    <= bit_reg - 5'd1;
                TGT_MOSI_O <= tx_reg[bit_reg - 5'd1];
              end
            end
          end
        end
        ST_DONE: begin
          TGT_MOSI_O <= 1'b0;
          if (op_reg == `ISP_CMD_ENABLE) begin
            // All four bytes went out regardless of echo
            if (rx_reg[15:8] == `ISP_PEN_B2) begin
              ENABLED_O   <= 1'b1;
              SYNC_FAIL_O <= 1'b0;
              state_reg   <= ST_IDLE;
            end else begin
              SYNC_FAIL_O  <= 1'b1;
              ENABLED_O    <= 1'b0;
              TGT_NRESET_O <= 1'b1;
              wait_reg     <= `ISP_RST_PULSE;
              state_reg    <= ST_PULSE;
            end
          end else if (op_reg == `ISP_CMD_RDPM || op_reg == `ISP_CMD_RDEE) begin
            push_valid_reg <= 1'b1;
            state_reg      <= ST_PUSH;
          end else if (op_reg == `ISP_CMD_WPAGE) begin
            wait_reg  <= FLASH_WAIT;
            state_reg <= ST_WAIT;
          end else if (op_reg == `ISP_CMD_WREE) begin
            wait_reg  <= EEPROM_WAIT;
            state_reg <= ST_WAIT;
          end else if (op_reg == `ISP_CMD_ERASE) begin
            wait_reg  <= ERASE_WAIT;
            state_reg <= ST_WAIT;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        ST_WAIT: begin
          // Fixed delay; polling cannot see all-ones data
          if (wait_reg <= 32'd1) begin
            state_reg <= ST_IDLE;
          end else begin
            wait_reg <= wait_reg - 32'd1;
          end
        end
        ST_PULSE: begin
          if (wait_reg <= 32'd1) begin
            TGT_NRESET_O <= 1'b0;
            wait_reg     <= ENTRY_WAIT;
            ENABLED_O    <= 1'b0;
            // Entry delay, then idle so the user resends enable
            state_reg    <= ST_WAIT;
          end else begin
            wait_reg <= wait_reg - 32'd1;
          end
        end
        ST_PUSH: begin
          // Back-pressure from the read stream stalls the engine
          if (fifo_ready) begin
            push_valid_reg <= 1'b0;
            state_reg      <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  isp_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_i      (CLOCK_I),
    .nrst_i     (NRST_I),
    .wr_data_i  (rx_reg[7:0]),
    .wr_valid_i (push_valid_reg),
    .wr_ready_o (fifo_ready),
    .rd_data_o  (RD_DATA_O),
    .rd_valid_o (RD_VALID_O),
    .rd_ready_i (RD_READY_I)
  );
endmodule // isp_host

// file: dv/isp_target_model.sv
/* Behavioural target of the serial programming link.
   Sees the host pins directly; its busy window is timed in ns. */
`timescale 1ns/1ps
module isp_target_model #(
  parameter BUSY_NS = 150
) (
  // Host pins
  input  wire nreset_i,
  input  wire sck_i,
  input  wire mosi_i,
  // Bench controls
  input  wire bad_echo_i,
  output wire miso_o,
  output reg  viol_o
);
  reg [7:0]  fl [0:8191];
  reg [7:0]  ee [0:511];
  reg [7:0]  pb [0:63];
  reg [31:0] sr;
  reg [7:0]  tx;
  reg [6:0]  pg;
  reg        en;
  integer    cnt;
  integer    i;
  realtime   busy_t;
  realtime   t0;
  // Released line flips so a stale bit never reads as data
  assign miso_o = nreset_i ? ~tx[7] : tx[7];
  initial begin
    for (i = 0; i < 8192; i = i + 1) fl[i] = 8'h00;
    for (i = 0; i < 512; i = i + 1) ee[i] = 8'h00;
    for (i = 0; i < 64; i = i + 1) pb[i] = 8'hff;
    sr = 32'h0;
    tx = 8'h00;
    pg = 7'h00;
    en = 1'b0;
    cnt = 0;
    viol_o = 1'b0;
    busy_t = 0.0;
    t0 = 0.0;
  end
  always @(posedge sck_i or posedge nreset_i) begin
    if (nreset_i) begin
      cnt = 0;
      en = 1'b0;
    end else begin
      sr = {sr[30:0], mosi_i};
      cnt = cnt + 1;
      // Frame start decides whether it overlapped a write
      if (cnt == 1) t0 = $realtime;
      if (cnt == 32) begin
        cnt = 0;
        if (t0 < busy_t && (sr[31:24] & 8'h77) != 8'h20) viol_o = 1'b1;
        if (sr[31:16] == 16'hac53) en = 1'b1;
        else if (en && sr[31:24] == 8'hac && sr[23:21] == 3'b100) begin
          for (i = 0; i < 8192; i = i + 1) fl[i] = 8'hff;
          for (i = 0; i < 512; i = i + 1) ee[i] = 8'hff;
          busy_t = $realtime + BUSY_NS;
        end else if (en && (sr[31:24] & 8'hf7) == 8'h40)
          pb[{sr[12:8], sr[27]}] = sr[7:0];
        else if (en && sr[31:24] == 8'h4c) begin
          pg = {sr[19:16], sr[15:13]};
          for (i = 0; i < 64; i = i + 1) begin
            fl[{pg, i[5:0]}] = pb[i];
            pb[i] = 8'hff;
          end
          busy_t = $realtime + BUSY_NS;
        end else if (en && sr[31:24] == 8'hc0) begin
          ee[{sr[16], sr[15:8]}] = sr[7:0];
          busy_t = $realtime + BUSY_NS;
        end
      end
    end
  end
  always @(negedge sck_i) begin
    if (!nreset_i) begin
      if (cnt == 16) tx = bad_echo_i ? ~sr[7:0] : sr[7:0];
      else if (cnt == 24 && (sr[23:16] & 8'hf7) == 8'h20)
        tx = ($realtime < busy_t && pg == sr[11:5]) ? 8'hff : fl[{sr[11:0], sr[19]}];
      else if (cnt == 24 && sr[23:16] == 8'ha0) tx = ee[sr[8:0]];
      else tx = {tx[6:0], 1'b0};
    end
  end
endmodule // isp_target_model

// file: dv/isp_host_checker.sv
/* Assertions on the programming host ports.
   Bound to isp_host; single clock domain. */
`timescale 1ns/1ps
module isp_host_checker #(
  parameter ENTRY_WAIT = 20
) (
  // Clock, reset, command
  input wire       CLOCK_I, NRST_I, CMD_VALID_I, CMD_READY_O,
  input wire [2:0] CMD_OP_I,
  // Status and read stream
  input wire       ENABLED_O, SYNC_FAIL_O, REFUSED_O, RD_VALID_O, RD_READY_I,
  input wire [7:0] RD_DATA_O,
  // Target pins
  input wire       TGT_NRESET_O, TGT_SCK_O, TGT_MOSI_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!NRST_I);
  reg        sck_q;
  reg [7:0]  run_reg;
  reg [7:0]  hi_reg;
  reg [5:0]  rise_reg;
  reg [31:0] ent_reg;
  wire       take = CMD_VALID_I && CMD_READY_O;
  always @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sck_q <= 1'b0;
      run_reg <= 8'h00;
      hi_reg <= 8'h00;
      rise_reg <= 6'h00;
      ent_reg <= 32'h0;
    end else begin
      sck_q <= TGT_SCK_O;
      run_reg <= (TGT_SCK_O != sck_q) ? 8'h01 : run_reg + {7'h00, run_reg != 8'hff};
      hi_reg <= TGT_NRESET_O ? hi_reg + {7'h00, hi_reg != 8'hff} : 8'h00;
      rise_reg <= take ? 6'h00 : rise_reg + {5'h00, TGT_SCK_O && !sck_q};
      ent_reg <= TGT_NRESET_O ? 32'h0 : ent_reg + 32'h1;
    end
  end
  sequence s_cold_take;
    take && !ENABLED_O && CMD_OP_I != 3'h0 && CMD_OP_I != 3'h7;
  endsequence
  sequence s_pulse;
    REFUSED_O ##1 !REFUSED_O;
  endsequence
  AST_IDLE_SCK: assert property (TGT_NRESET_O |-> !TGT_SCK_O)
    else $error("serial clock high outside session");
  AST_SCK_SESSION: assert property ($changed(TGT_SCK_O) |-> !TGT_NRESET_O)
    else $error("serial clock moved with target reset high");
  AST_SCK_HIGH: assert property (sck_q && !TGT_SCK_O |-> run_reg == 8'd50)
    else $error("serial clock high phase not 50 cycles");
  AST_SCK_LOW: assert property (!sck_q && TGT_SCK_O |-> run_reg >= 8'd50)
    else $error("serial clock low phase too short");
  AST_MOSI_HOLD: assert property (TGT_SCK_O |-> $stable(TGT_MOSI_O))
    else $error("data-in moved while serial clock high");
  AST_ENTRY_WAIT: assert property ($rose(TGT_SCK_O) |-> ent_reg >= ENTRY_WAIT)
    else $error("first clock before entry wait");
  AST_FRAME_BITS: assert property ($rose(CMD_READY_O) |-> rise_reg == 6'd32)
    else $error("frame not 32 clocks");
  AST_REFUSE: assert property (s_cold_take |-> ##[0:1] s_pulse)
    else $error("no single refusal pulse");
  AST_RESYNC: assert property ($fell(TGT_NRESET_O) && SYNC_FAIL_O |->
    hi_reg >= 8'd199 && hi_reg <= 8'd201)
    else $error("resync reset pulse width wrong");
  AST_LEAVE: assert property ($rose(TGT_NRESET_O) |=> !ENABLED_O)
    else $error("still enabled after reset release");
  AST_RD_HOLD: assert property (RD_VALID_O && !RD_READY_I |=>
    RD_VALID_O && $stable(RD_DATA_O))
    else $error("read byte dropped");
endmodule // isp_host_checker
bind isp_host isp_host_checker #(.ENTRY_WAIT(ENTRY_WAIT)) u_chk (
  .CLOCK_I(CLOCK_I), .NRST_I(NRST_I), .CMD_VALID_I(CMD_VALID_I),
  .CMD_READY_O(CMD_READY_O), .CMD_OP_I(CMD_OP_I), .ENABLED_O(ENABLED_O),
  .SYNC_FAIL_O(SYNC_FAIL_O), .REFUSED_O(REFUSED_O), .RD_VALID_O(RD_VALID_O),
  .RD_READY_I(RD_READY_I), .RD_DATA_O(RD_DATA_O), .TGT_NRESET_O(TGT_NRESET_O),
  .TGT_SCK_O(TGT_SCK_O), .TGT_MOSI_O(TGT_MOSI_O));

// file: dv/tb.sv
/* Bench for the programming host: drives commands, drains reads and
   judges replies against a behavioural target on the pins. */
`timescale 1ns/1ps
`include "isp_map.vh"
module tb;
  localparam W = 20;
  // Reads: op, high, address, expected byte
  localparam [10*28-1:0] TBL = {28'h4_0_3a0_5a, 28'h4_1_3a0_a5, 28'h4_0_3bf_01,
    28'h4_1_3bf_80, 28'h4_0_3a1_ff, 28'h4_1_3a1_ff, 28'h4_0_000_ff, 28'h5_0_1ff_ff,
    28'h5_0_010_ff, 28'h4_0_3a0_5a};
  reg        clk = 1'b0;
  reg        rst_n = 1'b0;
  reg        cmd_valid = 1'b0;
  reg        high = 1'b0;
  reg        rd_ready = 1'b0;
  reg        bad = 1'b0;
  reg [2:0]  op = 3'h0;
  reg [11:0] addr = 12'h000;
  reg [7:0]  data = 8'h00;
  wire       ready, rd_valid, en, sf, refd, nres, sck, mosi, miso, viol;
  wire [7:0] rd_data;
  integer    n_fail = 0;
  integer    tests_run = 0;
  integer    i;
  always #5 clk = ~clk;
  isp_host #(.ENTRY_WAIT(W), .FLASH_WAIT(W), .EEPROM_WAIT(W), .ERASE_WAIT(W)) dut (
    .CLOCK_I(clk), .NRST_I(rst_n), .CMD_VALID_I(cmd_valid), .CMD_READY_O(ready),
    .CMD_OP_I(op), .CMD_ADDR_I(addr), .CMD_HIGH_I(high), .CMD_DATA_I(data),
    .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid), .RD_READY_I(rd_ready),
    .ENABLED_O(en), .SYNC_FAIL_O(sf), .REFUSED_O(refd), .TGT_NRESET_O(nres),
    .TGT_SCK_O(sck), .TGT_MOSI_O(mosi), .TGT_MISO_I(miso));
  // Busy window ends just before a frame that honoured the wait may start
  isp_target_model #(.BUSY_NS(1150)) u_tgt (.nreset_i(nres), .sck_i(sck),
    .mosi_i(mosi), .bad_echo_i(bad), .miso_o(miso), .viol_o(viol));
  task stop_test;
    begin
      $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask
  task err(input string m);
    begin
      n_fail = n_fail + 1;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task cmp_bit(input got, input exp, input string m);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) err(m);
    end
  endtask
  task cmp_byte(input [7:0] got, input [7:0] exp, input string m);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) err(m);
    end
  endtask
  // Ends just after a rising edge, like every driver here
  task wait_ready;
    integer k;
    begin
      k = 0;
      @(negedge clk);
      while (ready !== 1'b1 && k < 9000) begin
        @(negedge clk);
        k = k + 1;
      end
      if (k >= 9000) err("ready never returned");
      @(posedge clk);
      #1;
    end
  endtask
  task send(input [2:0] o, input [11:0] a, input h, input [7:0] d);
    begin
      {op, addr, high, data} = {o, a, h, d};
      cmd_valid = 1'b1;
      wait_ready;
      cmd_valid = 1'b0;
    end
  endtask
  task run(input [2:0] o, input [11:0] a, input h, input [7:0] d);
    begin
      send(o, a, h, d);
      wait_ready;
    end
  endtask
  task pop(input [7:0] e);
    integer k;
    begin
      k = 0;
      @(negedge clk);
      while (rd_valid !== 1'b1 && k < 9000) begin
        @(negedge clk);
        k = k + 1;
      end
      if (k >= 9000) err("read byte never came");
      cmp_byte(rd_data, e, "read byte");
      @(posedge clk);
      #1 rd_ready = 1'b1;
      @(posedge clk);
      #1 rd_ready = 1'b0;
    end
  endtask
  task t_refuse;
    integer k, p;
    begin
      send(`ISP_CMD_ERASE, 12'h000, 1'b0, 8'h00);
      p = 0;
      for (k = 0; k < 4; k = k + 1) begin
        @(negedge clk);
        p = p + refd;
      end
      cmp_byte(p[7:0], 8'd1, "refusal pulses");
      cmp_bit(en, 1'b0, "enabled");
      cmp_bit(nres, 1'b1, "target reset");
      @(posedge clk);
      #1 $display("test refuse done");
    end
  endtask
  task t_sync;
    begin
      bad = 1'b1;
      run(`ISP_CMD_ENABLE, 12'h000, 1'b0, 8'h00);
      cmp_bit(sf, 1'b1, "bad echo flag");
      cmp_bit(en, 1'b0, "enabled on bad echo");
      bad = 1'b0;
      run(`ISP_CMD_ENABLE, 12'h000, 1'b0, 8'h00);
      cmp_bit(sf, 1'b0, "good echo flag");
      cmp_bit(en, 1'b1, "enabled");
      $display("test sync done");
    end
  endtask
  task t_flash;
    reg [27:0] e;
    begin
      run(`ISP_CMD_ERASE, 12'h000, 1'b0, 8'h00);
      run(`ISP_CMD_LOAD, 12'h3a0, 1'b0, 8'h5a);
      run(`ISP_CMD_LOAD, 12'h3a0, 1'b1, 8'ha5);
      run(`ISP_CMD_LOAD, 12'h3bf, 1'b0, 8'h01);
      run(`ISP_CMD_LOAD, 12'h3bf, 1'b1, 8'h80);
      run(`ISP_CMD_WPAGE, 12'h3a0, 1'b0, 8'h00);
      for (i = 0; i < 10; i = i + 1) begin
        e = TBL[(9 - i) * 28 +: 28];
        // A clock between requests so valid is never set twice in one step
        @(posedge clk);
        #1 send(e[26:24], e[19:8], e[20], 8'h00);
      end
      // Tenth byte stalls: eight queued plus one in the output register
      repeat (4000) @(posedge clk);
      #1 cmp_bit(ready, 1'b0, "stall on full buffer");
      for (i = 0; i < 10; i = i + 1) begin
        e = TBL[(9 - i) * 28 +: 28];
        pop(e[7:0]);
      end
      wait_ready;
      $display("test flash done");
    end
  endtask
  task t_eeprom;
    begin
      run(`ISP_CMD_WREE, 12'h1ff, 1'b0, 8'h3c);
      run(`ISP_CMD_WREE, 12'h1ff, 1'b0, 8'hc3);
      run(`ISP_CMD_WREE, 12'h000, 1'b0, 8'h00);
      run(`ISP_CMD_RDEE, 12'h1ff, 1'b0, 8'h00);
      pop(8'hc3);
      run(`ISP_CMD_RDEE, 12'h000, 1'b0, 8'h00);
      pop(8'h00);
      $display("test eeprom done");
    end
  endtask
  task t_leave;
    begin
      run(`ISP_CMD_LEAVE, 12'h000, 1'b0, 8'h00);
      cmp_bit(nres, 1'b1, "reset released");
      cmp_bit(en, 1'b0, "enabled after leave");
      $display("test leave done");
      t_refuse;
    end
  endtask
  initial begin
    #900000;
    err("watchdog expired");
    stop_test;
  end
  initial begin
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    t_refuse;
    t_sync;
    t_flash;
    t_eeprom;
    t_leave;
    cmp_bit(viol, 1'b0, "command during write");
    stop_test;
  end
endmodule // tb
